// ---- common/ram_consts.svh ----
`ifndef RAM_CONSTS_SVH
`define RAM_CONSTS_SVH
// Register indexes; byte address is four times the index
`define RAM_OFF_CTRL   10'h001
`define RAM_OFF_ALARM_ONE_IRQ_STATUS   10'h004
`define RAM_OFF_ALARM_TWO_IRQ_STATUS   10'h005
`define RAM_OFF_COUNTER_OVERFLOW_IRQ_STATUS   10'h007
`define RAM_OFF_PATTERN_IRQ_STATUS   10'h00B
`define RAM_OFF_IEN    10'h00C
`define RAM_OFF_RCFG   10'h040
`define RAM_OFF_PAT    10'h041
`define RAM_OFF_RX_ALARM_SIGNAL_CONFIG   10'h045
`define RAM_OFF_LATCH  10'h046
`define RAM_OFF_ALARM_ONE_STATUS   10'h047
`define RAM_OFF_ALARM_THREE_STATUS   10'h049
`define RAM_OFF_BERRL  10'h058
`define RAM_OFF_BERRH  10'h059
`define RAM_OFF_ALARM_EVENT_COUNTER   10'h05A
`define RAM_OFF_TX_ALARM_CONFIG   10'h075
// Field positions
`define RAM_CTRL_T1    7
`define RAM_CTRL_CAS   3
`define RAM_PAT_FRAMED 2
`define RAM_PAT_RUN    3
`define RAM_PAT_PATTERN_RESYNC 4
`define RAM_LAT_ALM    0
`define RAM_LAT_CNT    1
`define RAM_RX_ALARM_SIGNAL_CONFIG_INTEG 0
`define RAM_RX_ALARM_SIGNAL_CONFIG_ALSEL 1
`define RAM_TX_ALARM_CONFIG_AUTO  0
`define RAM_OVF_FAS    0
`define RAM_OVF_SEF    1
`define RAM_OVF_ALIGNMENT_CHANGE   2
`define RAM_OVF_PRBS_ERROR_COUNT_HIGH   3
// Reset values
`define RAM_RST_CTRL   8'h80
// Timing and thresholds
`define RAM_CLK_MHZ    125
`define RAM_ALOS_MS    1
`define RAM_T1_BPS     1544000
`define RAM_E1_BPS     2048000
`define RAM_AIS_T1_BITS 4632
`define RAM_AIS_E1_BITS 13'd512
`define RAM_AIS_T1_MAXZ 3'd4
`define RAM_AIS_E1_MAXZ 3'd2
`define RAM_MAIS_MAXZ  3'd3
`define RAM_LOS_T1     8'd100
`define RAM_LOS_E1     8'd32
`define RAM_PDV_ZEROS  8'd15
`define RAM_DENS_LAST  6'd63
`define RAM_DENS_ONES  4'd8
`define RAM_LOSW_LAST  7'd113
`define RAM_LOSW_ONES  7'd15
`define RAM_INTEG_HALF 3'd5
`define RAM_LOCK_LAST  6'd31
`define RAM_CLK_GAP    8'd64
`endif

// ---- common/ram_pkg.sv ----
`include "ram_consts.svh"
package ram_pkg;
    typedef struct packed {
        logic lclk, data, fas, mf, cas, severe_frame_error, alignment_change, ovh, ts16, mfs;
    } ram_pins_t;
    typedef enum logic [1:0] {PR_IDLE, PR_HUNT, PR_LOCK} ram_prbs_t;
    typedef struct packed {
        ram_pins_t   sync1, sync2, prev;
        logic [7:0]  ctrl, ien, rcfg, pat, rx_alarm_signal_config, latch, tx_alarm_config;
        logic [7:0]  alarm_one_irq_status, alarm_two_irq_status, counter_overflow_irq_status, pattern_irq_status, acc7;
        logic [4:0]  alm_prev;
        logic [7:0]  zrun;
        logic [5:0]  dcnt;
        logic [3:0]  dones;
        logic        dlow, los, losw;
        logic [6:0]  lcnt, lones;
        logic [19:0] acnt;
        logic [7:0]  gap;
        logic [12:0] wcnt;
        logic [2:0]  wz, mz, icnt;
        logic        e1ok, ais, mok, mais, lof_int, half;
        logic [1:0]  reason, sef_c, alignment_change_c;
        logic [20:0] scnt;
        logic [3:0]  fas_c, pz;
        logic [7:0]  alarm_event_counter_v, prbs_error_count_high_hi;
        logic [15:0] prbs_error_count_high, prbs_error_count_high_v;
        ram_prbs_t   pst;
        logic [22:0] lfsr;
        logic [5:0]  match;
        logic [31:0] prdata;
        logic        pready, pslverr, tx_ais, tick;
    } ram_state_t;
endpackage

// ---- hdl/ram_monitor.sv ----
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ram_consts.svh"
// What this block does
// - Flag density violation on over 15 zeros or ones density below 12.5%
// - Each alarm in the first status register has live status, interrupt enable and interrupt status bits
// - Status clears on read; latch option captures each second at the tick
// - E1 frame loss is OR of FAS, multiframe and CAS losses, readable apart
// - E1 frame loss reports a two-bit reason; T1 frame loss equals FAS loss
// - Frame loss live and interrupt status, enabled by its enable bit unless the alarm latch bit is set
// - Count FAS alignment losses in four bits, flag overflow
// - T1 integration holds frame loss over 2.0 to 2.5 seconds; count unaffected
// - Signal loss after 100 zeros in T1 or 32 in E1, status and interrupt
// - Signal loss clears on 12.5% density over 114 bits from a pulse
// - Automatic option sends alarm indication while signal loss is declared
// - Analog loss follows select bit: loss persisting 1 ms, or clock absent
// - T1 alarm indication: four or fewer zeros in 4632 bits during frame loss
// - E1 alarm indication: two double frames with two or fewer zeros, FAS lost
// - Severe frame error live status and 2-bit count with overflow flag
// - Each alignment change increments a 2-bit count with overflow flag
// - E1 CAS only: multiframe alarm indication on three or fewer TS16 zeros twice
// - Pattern receiver hunts selected PRBS, framed or not, optional zero limit
// - Overhead skipping excludes frame bit or timeslot 0 and CAS timeslot 16
// - Pattern receiver runs and counts errors only while run bit set
// - Pattern_resync write starts the sync search; further writes restart it
// - After sync, count pattern errors; clear on read or second latch, overflow
module ram_monitor
    import ram_pkg::*;
#(
    parameter int T1_BPS      = `RAM_T1_BPS,
    parameter int E1_BPS      = `RAM_E1_BPS,
    parameter int AIS_T1_BITS = `RAM_AIS_T1_BITS,
    parameter int ALOS_CYC    = 1000 * `RAM_CLK_MHZ * `RAM_ALOS_MS
) (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        rx_line_clock_i,
    input  wire logic        rx_data_i,
    input  wire logic        fas_alignment_loss_i,
    input  wire logic        multiframe_alignment_loss_i,
    input  wire logic        cas_alignment_loss_i,
    input  wire logic        severe_frame_error_i,
    input  wire logic        alignment_change_i,
    input  wire logic        overhead_bit_i,
    input  wire logic        ts16_bit_i,
    input  wire logic        multiframe_start_i,
    output logic             tx_alarm_indication_o,
    output logic             one_second_tick_o
);

    localparam logic [20:0] T1_HALF = 21'(T1_BPS / 2 - 1);
    localparam logic [20:0] E1_HALF = 21'(E1_BPS / 2 - 1);
    localparam logic [12:0] AIS_T1  = 13'(AIS_T1_BITS);
    localparam logic [19:0] ALOS_C  = 20'(ALOS_CYC);
    localparam ram_state_t  ST_RST  = '{ctrl: `RAM_RST_CTRL, pst: PR_IDLE, default: '0};

    function automatic logic known(input logic [9:0] a);
        case (a)
            `RAM_OFF_CTRL, `RAM_OFF_ALARM_ONE_IRQ_STATUS, `RAM_OFF_ALARM_TWO_IRQ_STATUS, `RAM_OFF_COUNTER_OVERFLOW_IRQ_STATUS, `RAM_OFF_PATTERN_IRQ_STATUS,
            `RAM_OFF_IEN, `RAM_OFF_RCFG, `RAM_OFF_PAT, `RAM_OFF_RX_ALARM_SIGNAL_CONFIG, `RAM_OFF_LATCH,
            `RAM_OFF_ALARM_ONE_STATUS, `RAM_OFF_ALARM_THREE_STATUS, `RAM_OFF_BERRL, `RAM_OFF_BERRH,
            `RAM_OFF_ALARM_EVENT_COUNTER, `RAM_OFF_TX_ALARM_CONFIG: known = 1'b1;
            default: known = 1'b0;
        endcase
    endfunction

    function automatic logic prbs_tap(input logic [22:0] r, input logic [1:0] sel);
        case (sel)
            2'd0: prbs_tap = r[10] ^ r[8];
            2'd1: prbs_tap = r[14] ^ r[13];
            2'd2: prbs_tap = r[19] ^ r[2];
            default: prbs_tap = r[22] ^ r[17];
        endcase
    endfunction

    ram_state_t s;
    ram_state_t n;
    ram_pins_t  pins_in;

    assign pins_in = '{lclk: rx_line_clock_i, data: rx_data_i,
                       fas: fas_alignment_loss_i, mf: multiframe_alignment_loss_i,
                       cas: cas_alignment_loss_i, severe_frame_error: severe_frame_error_i,
                       alignment_change: alignment_change_i, ovh: overhead_bit_i,
                       ts16: ts16_bit_i, mfs: multiframe_start_i};

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic        bit_en, d, t1, cas, acc, wr, rdx, setup, half_tick, sec_tick;
        logic        lof_raw, lof_live, alos, skip, expb, mism, zok;
        logic        fas_inc, sef_inc, alignment_change_inc, err, lat_a, lat_c, clr_a, clr_b;
        logic [9:0]  idx;
        logic [7:0]  los_thr, rdat;
        logic [4:0]  live, ev;
        logic [12:0] wlen;
        logic [2:0]  wz;
        logic [3:0]  fas_b;
        logic [1:0]  sef_b, alignment_change_b;
        logic [15:0] prbs_error_count_high_b;
        n = s;
        rdat = 8'h00;
        zok = 1'b0;
        idx = paddr_i[11:2];
        setup = psel_i & ~penable_i;
        acc = psel_i & penable_i & s.pready;
        wr = acc & pwrite_i;
        rdx = acc & ~pwrite_i & ~s.pslverr;
        lat_a = s.latch[`RAM_LAT_ALM];
        lat_c = s.latch[`RAM_LAT_CNT];

        // Line pins: two-flop synchronisers, then edge detect on the second stage
        n.sync1 = pins_in;
        n.sync2 = s.sync1;
        n.prev = s.sync2;
        bit_en = s.sync2.lclk & ~s.prev.lclk;
        d = s.sync2.data;
        t1 = s.ctrl[`RAM_CTRL_T1];
        cas = ~t1 & s.ctrl[`RAM_CTRL_CAS];

        // One-second tick from half-second line-bit counts
        half_tick = 1'b0;
        if (bit_en) begin
            if (s.scnt >= (t1 ? T1_HALF : E1_HALF)) begin
                n.scnt = '0;
                half_tick = 1'b1;
                n.half = ~s.half;
            end else begin
                n.scnt = s.scnt + 21'd1;
            end
        end
        sec_tick = half_tick & s.half;
        n.tick = sec_tick;

        // Zero run
        if (bit_en) begin
            n.zrun = d ? 8'd0 : (&s.zrun ? s.zrun : s.zrun + 8'd1);
        end

        // Density violation: long zero run or under 8 ones in 64 bits
        if (bit_en) begin
            n.dcnt = s.dcnt + 6'd1;
            if (d && s.dones != `RAM_DENS_ONES) begin
                n.dones = s.dones + 4'd1;
            end
            if (s.dcnt == `RAM_DENS_LAST) begin
                n.dlow = (n.dones < `RAM_DENS_ONES);
                n.dones = 4'd0;
            end
        end

        // Signal loss set and clear window
        los_thr = t1 ? `RAM_LOS_T1 : `RAM_LOS_E1;
        if (bit_en && s.los) begin
            if (!s.losw && d) begin
                n.losw = 1'b1;
                n.lcnt = 7'd1;
                n.lones = 7'd1;
            end else if (s.losw) begin
                n.lcnt = s.lcnt + 7'd1;
                n.lones = s.lones + {6'd0, d};
                if (s.lcnt == `RAM_LOSW_LAST) begin
                    n.losw = 1'b0;
                    n.los = (n.lones < `RAM_LOSW_ONES);
                end
            end
        end
        if (bit_en && !d && s.zrun == los_thr - 8'd1) begin
            n.los = 1'b1;
            n.losw = 1'b0;
        end
        n.tx_ais = s.tx_alarm_config[`RAM_TX_ALARM_CONFIG_AUTO] & s.los;

        // Analog loss: signal-loss persistence or missing line clock
        n.acnt = !s.los ? 20'd0 : (s.acnt == ALOS_C ? s.acnt : s.acnt + 20'd1);
        n.gap = bit_en ? 8'd0 : (s.gap == `RAM_CLK_GAP ? s.gap : s.gap + 8'd1);
        alos = s.rx_alarm_signal_config[`RAM_RX_ALARM_SIGNAL_CONFIG_ALSEL] ? (s.gap == `RAM_CLK_GAP)
                                       : (s.acnt == ALOS_C);

        // Frame loss, reason and integration
        lof_raw = t1 ? s.sync2.fas : (s.sync2.fas | s.sync2.mf | s.sync2.cas);
        if (!t1 && lof_raw && !(s.prev.fas | s.prev.mf | s.prev.cas)) begin
            n.reason = s.sync2.fas ? 2'd1 : (s.sync2.mf ? 2'd2 : 2'd3);
        end
        if (!(t1 && s.rx_alarm_signal_config[`RAM_RX_ALARM_SIGNAL_CONFIG_INTEG]) || lof_raw == s.lof_int) begin
            n.lof_int = lof_raw;
            n.icnt = 3'd0;
        end else if (half_tick) begin
            n.icnt = s.icnt + 3'd1;
            if (s.icnt == `RAM_INTEG_HALF - 3'd1) begin
                n.lof_int = lof_raw;
                n.icnt = 3'd0;
            end
        end
        lof_live = s.lof_int;

        // Alarm indication windows
        wlen = t1 ? AIS_T1 : `RAM_AIS_E1_BITS;
        wz = (!d && s.wz != 3'd7) ? s.wz + 3'd1 : s.wz;
        if (bit_en) begin
            n.wcnt = s.wcnt + 13'd1;
            n.wz = wz;
            if (s.wcnt >= wlen - 13'd1) begin
                n.wcnt = 13'd0;
                n.wz = 3'd0;
                zok = wz <= (t1 ? `RAM_AIS_T1_MAXZ : `RAM_AIS_E1_MAXZ);
                n.e1ok = zok;
                n.ais = t1 ? (zok & lof_live)
                           : (zok & s.e1ok & s.sync2.fas);
            end
        end

        // Multiframe alarm indication on timeslot 16
        if (bit_en) begin
            if (s.sync2.mfs) begin
                zok = s.mz <= `RAM_MAIS_MAXZ;
                n.mok = zok;
                n.mais = cas & zok & s.mok;
                n.mz = 3'd0;
            end else if (s.sync2.ts16 && !d && s.mz != 3'd7) begin
                n.mz = s.mz + 3'd1;
            end
        end
        if (!cas) begin
            n.mais = 1'b0;
        end

        // Live alarms, events and the first interrupt status
        live = {s.ais, alos, s.los, lof_live, (s.zrun > `RAM_PDV_ZEROS) | s.dlow};
        n.alm_prev = live;
        ev = live & ~s.alm_prev;
        if (lat_a) begin
            n.acc7 = s.acc7 | {3'd0, ev};
            if (sec_tick) begin
                n.alarm_one_irq_status = s.acc7 | {3'd0, ev};
                n.acc7 = 8'h00;
            end
        end else begin
            n.acc7 = 8'h00;
            n.alarm_one_irq_status = (s.alarm_one_irq_status & ~((rdx && idx == `RAM_OFF_ALARM_ONE_IRQ_STATUS) ? s.prdata[7:0] : 8'h00))
                   | ({3'd0, ev} & s.ien);
        end
        n.alarm_two_irq_status = (s.alarm_two_irq_status & ~((rdx && idx == `RAM_OFF_ALARM_TWO_IRQ_STATUS) ? s.prdata[7:0] : 8'h00))
               | {7'd0, sec_tick};

        // Alarm event counter
        fas_inc = s.sync2.fas & ~s.prev.fas;
        sef_inc = s.sync2.severe_frame_error & ~s.prev.severe_frame_error;
        alignment_change_inc = s.sync2.alignment_change & ~s.prev.alignment_change;
        clr_a = ~lat_c & rdx & (idx == `RAM_OFF_ALARM_EVENT_COUNTER);
        fas_b = clr_a ? s.fas_c - s.prdata[3:0] : (lat_c & sec_tick ? 4'd0 : s.fas_c);
        sef_b = clr_a ? s.sef_c - s.prdata[5:4] : (lat_c & sec_tick ? 2'd0 : s.sef_c);
        alignment_change_b = clr_a ? s.alignment_change_c - s.prdata[7:6] : (lat_c & sec_tick ? 2'd0 : s.alignment_change_c);
        if (lat_c && sec_tick) begin
            n.alarm_event_counter_v = {s.alignment_change_c, s.sef_c, s.fas_c};
        end
        n.fas_c = fas_b + {3'd0, fas_inc};
        n.sef_c = sef_b + {1'd0, sef_inc};
        n.alignment_change_c = alignment_change_b + {1'd0, alignment_change_inc};

        // Pattern receiver
        skip = s.pat[`RAM_PAT_FRAMED] & (s.sync2.ovh | (cas & s.sync2.ts16));
        expb = prbs_tap(s.lfsr, s.pat[1:0]);
        if (s.pat[7:5] != 3'd0 && s.pz >= {1'b0, s.pat[7:5]}) begin
            expb = 1'b1;
        end
        mism = d ^ expb;
        err = 1'b0;
        case (s.pst)
            PR_IDLE: begin
            end
            PR_HUNT, PR_LOCK: begin
                if (bit_en && !skip) begin
                    n.lfsr = {s.lfsr[21:0], d};
                    n.pz = d ? 4'd0 : (&s.pz ? s.pz : s.pz + 4'd1);
                    if (s.pst == PR_HUNT) begin
                        n.match = mism ? 6'd0 : s.match + 6'd1;
                        if (!mism && s.match == `RAM_LOCK_LAST) begin
                            n.pst = PR_LOCK;
                        end
                    end else begin
                        err = mism;
                    end
                end
            end
            default: n.pst = PR_IDLE;
        endcase
        if (!s.pat[`RAM_PAT_RUN]) begin
            n.pst = PR_IDLE;
        end
        if (wr && idx == `RAM_OFF_PAT && pwdata_i[`RAM_PAT_PATTERN_RESYNC] && pwdata_i[`RAM_PAT_RUN]) begin
            n.pst = PR_HUNT;
            n.match = 6'd0;
            n.pz = 4'd0;
        end
        n.pattern_irq_status = (s.pattern_irq_status & ~((rdx && idx == `RAM_OFF_PATTERN_IRQ_STATUS) ? s.prdata[7:0] : 8'h00))
               | {7'd0, n.pst == PR_LOCK && s.pst == PR_HUNT};

        // Pattern error counter
        clr_b = ~lat_c & rdx & (idx == `RAM_OFF_BERRL);
        prbs_error_count_high_b = clr_b ? s.prbs_error_count_high - {s.prbs_error_count_high_hi, s.prdata[7:0]}
                       : (lat_c & sec_tick ? 16'd0 : s.prbs_error_count_high);
        if (lat_c && sec_tick) begin
            n.prbs_error_count_high_v = s.prbs_error_count_high;
        end
        n.prbs_error_count_high = prbs_error_count_high_b + {15'd0, err};

        n.counter_overflow_irq_status = (s.counter_overflow_irq_status & ~((rdx && idx == `RAM_OFF_COUNTER_OVERFLOW_IRQ_STATUS) ? s.prdata[7:0] : 8'h00))
               | {4'd0, err & (&prbs_error_count_high_b), alignment_change_inc & (&alignment_change_b),
                  sef_inc & (&sef_b), fas_inc & (&fas_b)};

        // APB register file
        if (wr) begin
            case (idx)
                `RAM_OFF_CTRL:  n.ctrl = pwdata_i[7:0];
                `RAM_OFF_IEN:   n.ien = pwdata_i[7:0];
                `RAM_OFF_RCFG:  n.rcfg = pwdata_i[7:0];
                `RAM_OFF_PAT:   n.pat = pwdata_i[7:0] & ~(8'h01 << `RAM_PAT_PATTERN_RESYNC);
                `RAM_OFF_RX_ALARM_SIGNAL_CONFIG:  n.rx_alarm_signal_config = pwdata_i[7:0];
                `RAM_OFF_LATCH: n.latch = pwdata_i[7:0];
                `RAM_OFF_TX_ALARM_CONFIG:  n.tx_alarm_config = pwdata_i[7:0];
                default: begin
                end
            endcase
        end
        case (idx)
            `RAM_OFF_CTRL:  rdat = s.ctrl;
            `RAM_OFF_ALARM_ONE_IRQ_STATUS:  rdat = s.alarm_one_irq_status;
            `RAM_OFF_ALARM_TWO_IRQ_STATUS:  rdat = s.alarm_two_irq_status;
            `RAM_OFF_COUNTER_OVERFLOW_IRQ_STATUS:  rdat = s.counter_overflow_irq_status;
            `RAM_OFF_PATTERN_IRQ_STATUS:  rdat = s.pattern_irq_status;
            `RAM_OFF_IEN:   rdat = s.ien;
            `RAM_OFF_RCFG:  rdat = s.rcfg;
            `RAM_OFF_PAT:   rdat = s.pat;
            `RAM_OFF_RX_ALARM_SIGNAL_CONFIG:  rdat = s.rx_alarm_signal_config;
            `RAM_OFF_LATCH: rdat = s.latch;
            `RAM_OFF_ALARM_ONE_STATUS:  rdat = {3'd0, live};
            `RAM_OFF_ALARM_THREE_STATUS:  rdat = {1'b0, s.mais, s.sync2.severe_frame_error, s.reason,
                                    s.sync2.cas, s.sync2.mf, s.sync2.fas};
            `RAM_OFF_BERRL: rdat = lat_c ? s.prbs_error_count_high_v[7:0] : s.prbs_error_count_high[7:0];
            `RAM_OFF_BERRH: rdat = lat_c ? s.prbs_error_count_high_v[15:8] : s.prbs_error_count_high_hi;
            `RAM_OFF_ALARM_EVENT_COUNTER:  rdat = lat_c ? s.alarm_event_counter_v : {s.alignment_change_c, s.sef_c, s.fas_c};
            `RAM_OFF_TX_ALARM_CONFIG:  rdat = s.tx_alarm_config;
            default:        rdat = 8'h00;
        endcase
        n.pready = setup;
        n.pslverr = setup & ~known(idx);
        if (setup) begin
            n.prdata = {24'd0, rdat};
            if (idx == `RAM_OFF_BERRL && !pwrite_i) begin
                n.prbs_error_count_high_hi = s.prbs_error_count_high[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata_o = s.prdata;
    assign pready_o = s.pready;
    assign pslverr_o = s.pslverr;
    assign tx_alarm_indication_o = s.tx_ais;
    assign one_second_tick_o = s.tick;

endmodule

// ---- tb/ram_monitor_checker.sv ----
`timescale 1ns/1ps
module ram_monitor_checker (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        rx_data_i,
    input wire logic        tx_alarm_indication_o,
    input wire logic        one_second_tick_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence answer_s;
        pready_o ##1 !pready_o;
    endsequence
    apb_answer_a: assert property (setup_s |=> answer_s)
        else $error("no single ready after setup");
    ready_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i))
        else $error("ready without setup");
    access_only_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    unmapped_err_a: assert property (pready_o && $past(paddr_i[11:9]) != 3'b000 |-> pslverr_o)
        else $error("unmapped access not refused");
    upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    tick_pulse_a: assert property (one_second_tick_o |=> !one_second_tick_o [*8])
        else $error("second tick too long");
    ais_cause_a: assert property ($rose(tx_alarm_indication_o) |-> !$past(rx_data_i, 8))
        else $error("alarm sent while line active");
endmodule

bind ram_monitor ram_monitor_checker chk (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rx_data_i(rx_data_i), .tx_alarm_indication_o(tx_alarm_indication_o),
    .one_second_tick_o(one_second_tick_o)
);

// ---- tb/ram_liu_model.sv ----
`timescale 1ns/1ps
module ram_liu_model (
    input  wire logic run_i,
    input  wire logic bit_i,
    output logic      line_clock_o,
    output logic      data_o
);
    initial begin
        line_clock_o = 1'b0;
        data_o = 1'b1;
    end
    ////////////////////////////////////////
    // Data changes on the falling line edge; released data toggles
    always begin
        #80;
        if (run_i) begin
            line_clock_o = ~line_clock_o;
            if (!line_clock_o) data_o = bit_i;
        end else begin
            line_clock_o = 1'b0;
            data_o = ~data_o;
        end
    end
endmodule

// ---- tb/ram_monitor_tb.sv ----
`timescale 1ns/1ps
`include "ram_consts.svh"
module ram_monitor_tb;
    logic        clock_i, reset_n_i, psel, penable, pwrite, run, lbit, err, ovh, ts16, mfs;
    logic        pready, pslverr, lclk, ldata, fas, mfl, casl, severe_frame_error, alignment_change, tx_ais, tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          error_cnt, checked, n;
    ram_monitor #(.T1_BPS(200), .E1_BPS(256), .AIS_T1_BITS(64), .ALOS_CYC(200)) uut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_line_clock_i(lclk), .rx_data_i(ldata),
        .fas_alignment_loss_i(fas), .multiframe_alignment_loss_i(mfl),
        .cas_alignment_loss_i(casl), .severe_frame_error_i(severe_frame_error), .alignment_change_i(alignment_change),
        .overhead_bit_i(ovh), .ts16_bit_i(ts16), .multiframe_start_i(mfs),
        .tx_alarm_indication_o(tx_ais), .one_second_tick_o(tick));
    ram_liu_model liu (.run_i(run), .bit_i(lbit), .line_clock_o(lclk), .data_o(ldata));
    always #4 clock_i = ~clock_i;
    ////////////////////////////////////////
    task summarize;
        $display("counts: %0d checked, %0d wrong", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int k;
        @(posedge clock_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {idx, 2'b00}; pwdata <= {24'h00_0000, d};
        @(posedge clock_i);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clock_i); k++; end while (pready !== 1'b1 && k < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 20) begin error_cnt++; summarize(); end
    endtask
    task rd(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e);
        repeat (4) @(posedge clock_i);
        apb(1'b0, idx, 8'h00);
        check(q & {24'h00_0000, m}, {24'h00_0000, e});
    endtask
    task send(input logic b, input int nb);
        @(posedge clock_i) lbit <= b;
        repeat (nb) @(posedge lclk);
        repeat (8) @(posedge clock_i);
    endtask
    task pulse(input int which, input int cnt);
        repeat (cnt) begin
            @(posedge clock_i) {fas, severe_frame_error, alignment_change} <= 3'b001 << which;
            repeat (6) @(posedge clock_i);
            {fas, severe_frame_error, alignment_change} <= 3'b000;
            repeat (6) @(posedge clock_i);
        end
    endtask
    ////////////////////////////////////////
    task t_regs;
        rd(`RAM_OFF_CTRL, 8'hFF, 8'h80);
        apb(1'b1, `RAM_OFF_IEN, 8'h1F);
        rd(`RAM_OFF_IEN, 8'hFF, 8'h1F);
        apb(1'b0, 10'h200, 8'h00);
        check({31'h0000_0000, err}, 32'h0000_0001);
        $display("test regs done");
    endtask
    task t_los;
        apb(1'b1, `RAM_OFF_TX_ALARM_CONFIG, 8'h01);
        send(1'b1, 130);
        rd(`RAM_OFF_ALARM_ONE_STATUS, 8'h0D, 8'h00);
        send(1'b0, 115);
        rd(`RAM_OFF_ALARM_ONE_STATUS, 8'h0D, 8'h0D);
        check({31'h0000_0000, tx_ais}, 32'h0000_0001);
        rd(`RAM_OFF_ALARM_ONE_IRQ_STATUS, 8'h05, 8'h05);
        rd(`RAM_OFF_ALARM_ONE_IRQ_STATUS, 8'h05, 8'h00);
        send(1'b1, 120);
        rd(`RAM_OFF_ALARM_ONE_STATUS, 8'h04, 8'h00);
        check({31'h0000_0000, tx_ais}, 32'h0000_0000);
        $display("test signal loss done");
    endtask
    task t_frame;
        apb(1'b1, `RAM_OFF_CTRL, 8'h08);
        mfl <= 1'b1;
        rd(`RAM_OFF_ALARM_ONE_STATUS, 8'h02, 8'h02);
        rd(`RAM_OFF_ALARM_THREE_STATUS, 8'h1F, 8'h12);
        casl <= 1'b1;
        rd(`RAM_OFF_ALARM_THREE_STATUS, 8'h07, 8'h06);
        {mfl, casl} <= 2'b00;
        apb(1'b1, `RAM_OFF_CTRL, 8'h80);
        fas <= 1'b1;
        rd(`RAM_OFF_ALARM_ONE_STATUS, 8'h02, 8'h02);
        fas <= 1'b0;
        rd(`RAM_OFF_ALARM_ONE_STATUS, 8'h02, 8'h00);
        $display("test frame loss done");
    endtask
    task t_mais;
        apb(1'b1, `RAM_OFF_CTRL, 8'h08);
        mfs <= 1'b1;
        send(1'b1, 4);
        rd(`RAM_OFF_ALARM_THREE_STATUS, 8'h40, 8'h40);
        apb(1'b1, `RAM_OFF_CTRL, 8'h00);
        rd(`RAM_OFF_ALARM_THREE_STATUS, 8'h40, 8'h00);
        mfs <= 1'b0;
        apb(1'b1, `RAM_OFF_CTRL, 8'h80);
        $display("test multiframe alarm done");
    endtask
    task t_cnt;
        apb(1'b0, `RAM_OFF_ALARM_EVENT_COUNTER, 8'h00);
        pulse(0, 4);
        pulse(1, 4);
        pulse(2, 3);
        rd(`RAM_OFF_ALARM_EVENT_COUNTER, 8'hFF, 8'h03);
        rd(`RAM_OFF_COUNTER_OVERFLOW_IRQ_STATUS, 8'h07, 8'h06);
        $display("test counters done");
    endtask
    task t_alos;
        apb(1'b1, `RAM_OFF_RX_ALARM_SIGNAL_CONFIG, 8'h02);
        run <= 1'b0;
        repeat (100) @(posedge clock_i);
        rd(`RAM_OFF_ALARM_ONE_STATUS, 8'h08, 8'h08);
        run <= 1'b1;
        repeat (60) @(posedge clock_i);
        rd(`RAM_OFF_ALARM_ONE_STATUS, 8'h08, 8'h00);
        $display("test clock loss done");
    endtask
    task t_tick;
        n = 0;
        while (tick !== 1'b1 && n < 10000) begin @(posedge clock_i); n++; end
        if (n >= 10000) begin error_cnt++; summarize(); end
        rd(`RAM_OFF_ALARM_TWO_IRQ_STATUS, 8'h01, 8'h01);
        rd(`RAM_OFF_ALARM_TWO_IRQ_STATUS, 8'h01, 8'h00);
        $display("test second tick done");
    endtask
    initial begin
        clock_i = 1'b0; reset_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; run = 1'b1; lbit = 1'b1;
        {fas, mfl, casl, severe_frame_error, alignment_change, ovh, ts16, mfs} = 8'h00;
        error_cnt = 0;
        checked = 0;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_los();
        t_frame();
        t_mais();
        t_cnt();
        t_alos();
        t_tick();
        summarize();
    end
endmodule
